// ---- rtl/srlo_regs.svh ----
`ifndef SRLO_REGS_SVH
`define SRLO_REGS_SVH
// Opcode pattern for the rotate-right-through-carry instruction
`define SRLO_OPC_MASK 12'hFC0
`define SRLO_OPC_MATCH 12'h300
`define SRLO_DEST_BIT 5
`define SRLO_ADDR_MSB 4
`define SRLO_ACC_RESET 8'h00
`define SRLO_CARRY_RESET 1'b0
`endif

// ---- rtl/srlo_pkg.sv ----
package srlo_pkg;
	typedef logic [7:0] srlo_byte_t;
	typedef logic [4:0] srlo_addr_t;
	typedef logic [11:0] srlo_word_t;
endpackage

// ---- rtl/srlo_shift_right_link_op.sv ----
// Behaviour
// - Rotate right: carry into bit 7, bit 0 out
// - Destination 0: result to accumulator only
// - Destination 1: result back to location
// - Decode 0011 00df ffff, d bit 5
`timescale 1ns/1ps
`include "srlo_regs.svh"
module srlo_shift_right_link_op (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic clk_en_in,
	input wire logic instr_valid_in,
	input wire srlo_pkg::srlo_word_t instr_in,
	input wire srlo_pkg::srlo_byte_t mem_rdata_in,
	output srlo_pkg::srlo_addr_t mem_addr_out,
	output logic mem_we_out,
	output srlo_pkg::srlo_byte_t mem_wdata_out,
	output srlo_pkg::srlo_byte_t acc_out,
	output logic carry_out,
	output logic done_out
);
	////////////////////////////////////////////////////////////////
	// Decode and datapath
	logic hit;
	logic dest;
	srlo_pkg::srlo_byte_t result;
	logic carry_q;
	srlo_pkg::srlo_byte_t acc_q;
	assign hit = instr_valid_in && ((instr_in & `SRLO_OPC_MASK) == `SRLO_OPC_MATCH);
	assign dest = instr_in[`SRLO_DEST_BIT];
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_rot
			assign result[gi] = mem_rdata_in[gi + 1];
		end
	endgenerate
	assign result[7] = carry_q;

	// Location address is combinational so the read completes in-cycle
	assign mem_addr_out = instr_in[`SRLO_ADDR_MSB:0];

	////////////////////////////////////////////////////////////////
	// Carry flag
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			carry_q <= `SRLO_CARRY_RESET;
		end else if (clk_en_in && hit) begin
			carry_q <= mem_rdata_in[0];
		end
	end
	assign carry_out = carry_q;

	////////////////////////////////////////////////////////////////
	// Accumulator
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			acc_q <= `SRLO_ACC_RESET;
		end else if (clk_en_in && hit && !dest) begin
			acc_q <= result;
		end
	end
	assign acc_out = acc_q;

	////////////////////////////////////////////////////////////////
	// Write-back strobe, combinational so it lands in the same cycle
	assign mem_we_out = clk_en_in && hit && dest;
	assign mem_wdata_out = result;

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			done_out <= 1'b0;
		end else if (clk_en_in) begin
			done_out <= hit;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	property p_carry;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && hit) |=> (carry_q == $past(mem_rdata_in[0]));
	endproperty
	AST_CARRY: assert property (p_carry) else $error("carry not taken from bit 0");

	property p_acc;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && hit && !dest) |=> (acc_q == {$past(carry_q), $past(mem_rdata_in[7:1])});
	endproperty
	AST_ACC: assert property (p_acc) else $error("accumulator result wrong");

	property p_wb;
		@(posedge mclk_in) disable iff (!arst_n_in)
		mem_we_out |-> (dest && mem_wdata_out == {carry_q, mem_rdata_in[7:1]});
	endproperty
	AST_WB: assert property (p_wb) else $error("write-back wrong");

	property p_no_we;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(hit && !dest) |-> !mem_we_out;
	endproperty
	AST_NO_WE: assert property (p_no_we) else $error("location written with d 0");

	property p_acc_hold;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && hit && dest) |=> $stable(acc_q);
	endproperty
	AST_ACC_HOLD: assert property (p_acc_hold) else $error("accumulator changed with d 1");

	property p_decode;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && instr_in[11:6] != 6'h0C) |=> $stable(carry_q) && !done_out;
	endproperty
	AST_DECODE: assert property (p_decode) else $error("other opcode acted");

	property p_one_cycle;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && hit) |=> done_out;
	endproperty
	AST_ONE_CYCLE: assert property (p_one_cycle) else $error("not done in one cycle");

	property p_freeze;
		@(posedge mclk_in) disable iff (!arst_n_in)
		!clk_en_in |=> $stable(carry_q) && $stable(acc_q);
	endproperty
	AST_FREEZE: assert property (p_freeze) else $error("state moved while frozen");

	////////////////////////////////////////////////////////////////
	// Sequences for multi-step checks
	sequence s_take;
		clk_en_in && hit;
	endsequence

	sequence s_take_wb;
		clk_en_in && hit && dest;
	endsequence

	sequence s_take_acc;
		clk_en_in && hit && !dest;
	endsequence

	////////////////////////////////////////////////////////////////
	// Further checks
	property p_carry_idle;
		@(posedge mclk_in) disable iff (!arst_n_in)
		!(clk_en_in && hit) |=> $stable(carry_q);
	endproperty
	AST_CARRY_IDLE: assert property (p_carry_idle) else $error("carry moved without instruction");

	property p_acc_idle;
		@(posedge mclk_in) disable iff (!arst_n_in)
		!(clk_en_in && hit && !dest) |=> $stable(acc_q);
	endproperty
	AST_ACC_IDLE: assert property (p_acc_idle) else $error("accumulator moved without d 0");

	property p_done_idle;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && !hit) |=> !done_out;
	endproperty
	AST_DONE_IDLE: assert property (p_done_idle) else $error("done without instruction");

	property p_we_frozen;
		@(posedge mclk_in) disable iff (!arst_n_in)
		!clk_en_in |-> !mem_we_out;
	endproperty
	AST_WE_FROZEN: assert property (p_we_frozen) else $error("write while frozen");

	property p_we_invalid;
		@(posedge mclk_in) disable iff (!arst_n_in)
		!instr_valid_in |-> !mem_we_out;
	endproperty
	AST_WE_INVALID: assert property (p_we_invalid) else $error("write without valid word");

	property p_we_take;
		@(posedge mclk_in) disable iff (!arst_n_in)
		s_take_wb |-> mem_we_out;
	endproperty
	AST_WE_TAKE: assert property (p_we_take) else $error("write missing with d 1");

	property p_wdata_low;
		@(posedge mclk_in) disable iff (!arst_n_in)
		mem_we_out |-> (mem_wdata_out[6:0] == mem_rdata_in[7:1]);
	endproperty
	AST_WDATA_LOW: assert property (p_wdata_low) else $error("write data low bits wrong");

	property p_wdata_top;
		@(posedge mclk_in) disable iff (!arst_n_in)
		mem_we_out |-> (mem_wdata_out[7] == carry_out);
	endproperty
	AST_WDATA_TOP: assert property (p_wdata_top) else $error("write data top bit wrong");

	property p_chain;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(s_take ##1 s_take_acc) |=> (acc_q[7] == $past(carry_q));
	endproperty
	AST_CHAIN: assert property (p_chain) else $error("carry did not chain");

	property p_carry_wb;
		@(posedge mclk_in) disable iff (!arst_n_in)
		s_take_wb |=> (carry_q == $past(mem_rdata_in[0]));
	endproperty
	AST_CARRY_WB: assert property (p_carry_wb) else $error("carry wrong with d 1");

	property p_done_pulse;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(s_take ##1 (clk_en_in && !hit)) |=> !done_out;
	endproperty
	AST_DONE_PULSE: assert property (p_done_pulse) else $error("done held too long");

	property p_addr;
		@(posedge mclk_in) disable iff (!arst_n_in)
		hit |-> (mem_addr_out == instr_in[`SRLO_ADDR_MSB:0]);
	endproperty
	AST_ADDR: assert property (p_addr) else $error("location address wrong");

	property p_invalid;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && !instr_valid_in) |=> $stable(carry_q) && $stable(acc_q) && !done_out;
	endproperty
	AST_INVALID: assert property (p_invalid) else $error("acted without valid word");

	property p_freeze_done;
		@(posedge mclk_in) disable iff (!arst_n_in)
		!clk_en_in |=> $stable(done_out);
	endproperty
	AST_FREEZE_DONE: assert property (p_freeze_done) else $error("done moved while frozen");

	property p_result_msb;
		@(posedge mclk_in) disable iff (!arst_n_in)
		s_take_acc |=> (acc_q[7] == $past(carry_q));
	endproperty
	AST_RESULT_MSB: assert property (p_result_msb) else $error("old carry not in bit 7");
endmodule

// ---- test/srlo_shift_right_link_op_bench.sv ----
`timescale 1ns/1ps
module srlo_shift_right_link_op_bench;
logic mclk_in = 0, arst_n_in = 0, clk_en_in = 0, instr_valid_in = 0, mem_we_out, carry_out, done_out;
srlo_pkg::srlo_word_t instr_in = '0;
srlo_pkg::srlo_byte_t mem_rdata_in = '0, mem_wdata_out, acc_out;
srlo_pkg::srlo_addr_t mem_addr_out;
int fail_count = 0, check_count = 0;
always #20 mclk_in = ~mclk_in;
srlo_shift_right_link_op u_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en_in),
	.instr_valid_in(instr_valid_in), .instr_in(instr_in), .mem_rdata_in(mem_rdata_in),
	.mem_addr_out(mem_addr_out), .mem_we_out(mem_we_out), .mem_wdata_out(mem_wdata_out),
	.acc_out(acc_out), .carry_out(carry_out), .done_out(done_out));
task automatic chk(logic [7:0] seen, logic [7:0] exp);
	check_count++;
	if (seen !== exp) begin
		fail_count++;
		$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
	end
endtask
task automatic tally_and_finish();
	$display("checks %0d mismatches %0d", check_count, fail_count);
	if (fail_count == 0 && check_count > 0) $display("bench passed");
	else $display("bench failed");
	$finish;
endtask
////////////////////////////////////////////////////////////
// One request, then state after its edge
task automatic op(logic en, logic [11:0] ins, logic [7:0] rd, logic we, logic [7:0] wd, logic [7:0] a, logic c, logic dn);
	@(negedge mclk_in);
	clk_en_in = en;
	instr_valid_in = 1;
	instr_in = ins;
	mem_rdata_in = rd;
	#1;
	chk(8'(mem_we_out), 8'(we));
	chk(8'(mem_addr_out), 8'(ins[4:0]));
	if (we) chk(mem_wdata_out, wd);
	@(negedge mclk_in);
	instr_valid_in = 0;
	chk(acc_out, a);
	chk(8'(carry_out), 8'(c));
	chk(8'(done_out), 8'(dn));
endtask
task automatic t_reset();
	chk(acc_out, 8'h00);
	chk(8'(carry_out), 8'h00);
	chk(8'(done_out), 8'h00);
endtask
task automatic t_invalid();
	@(negedge mclk_in);
	clk_en_in = 1;
	instr_valid_in = 0;
	instr_in = 12'h320;
	mem_rdata_in = 8'hFF;
	#1;
	chk(8'(mem_we_out), 8'h00);
	@(negedge mclk_in);
	chk(8'(carry_out), 8'h01);
	chk(8'(done_out), 8'h00);
endtask
task automatic t_mid_reset();
	op(1'b1, 12'h300, 8'h03, 1'b0, 8'h00, 8'h81, 1'b1, 1'b1);
	@(negedge mclk_in);
	arst_n_in = 0;
	#1;
	chk(acc_out, 8'h00);
	chk(8'(carry_out), 8'h00);
	chk(8'(done_out), 8'h00);
	@(negedge mclk_in);
	arst_n_in = 1;
	op(1'b1, 12'h300, 8'hE6, 1'b0, 8'h00, 8'h73, 1'b0, 1'b1);
endtask
task automatic t_dest0();
	op(1'b1, 12'h305, 8'hE6, 1'b0, 8'h00, 8'h73, 1'b0, 1'b1);
	op(1'b1, 12'h31F, 8'h01, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1);
endtask
task automatic t_dest1();
	op(1'b1, 12'h33F, 8'h02, 1'b1, 8'h81, 8'h00, 1'b0, 1'b1);
	op(1'b1, 12'h320, 8'h4B, 1'b1, 8'h25, 8'h00, 1'b1, 1'b1);
endtask
task automatic t_refuse();
	op(1'b1, 12'h340, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0);
	op(1'b0, 12'h320, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0);
endtask
initial begin
	repeat (12) @(negedge mclk_in);
	t_reset();
	arst_n_in = 1;
	t_dest0();
	t_dest1();
	t_refuse();
	t_invalid();
	t_mid_reset();
	tally_and_finish();
end
endmodule
